//--- logic/sram_port_pkg.sv
// Purpose: shared constants for the two-word burst DDR SRAM port
// Assumes: nothing beyond SystemVerilog packages
// Notes:   widths here are defaults; the top module takes them as parameters
package sram_port_pkg;
    localparam int   LANE_W         = 9;
    localparam int   DATA_W_DFLT    = 18;
    localparam int   ADDR_W_DFLT    = 6;
    localparam int   LOG_DEPTH_DFLT = 8;
    localparam int   FIFO_W_DFLT    = 8;
    localparam logic DIR_READ       = 1'b1;
    localparam logic STROBE_ACTIVE  = 1'b0;
    localparam logic LANE_WRITE     = 1'b0;
    localparam logic BYPASS_ACTIVE  = 1'b0;
    localparam logic BURST_LSB_FLIP = 1'b1;
    localparam logic OE_RST         = 1'b0;
    localparam logic PEND_RST       = 1'b0;
endpackage : sram_port_pkg

//--- logic/cdc_word_fifo.sv
// Purpose: dual-clock word FIFO with gray-coded pointers
// Assumes: both resets synchronous to their own clock
// Notes:   depth must be a power of two, at least four
`timescale 1ns/10ps
module cdc_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // fill side
    input  wire logic             wr_clk,
    input  wire logic             wr_rst,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    // drain side
    input  wire logic             rd_clk,
    input  wire logic             rd_rst,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 4 || (1 << PW) != DEPTH) begin : g_chk
        $error("cdc_word_fifo: DEPTH must be a power of two of at least 4");
    end

    typedef struct packed {
        logic [PW:0]                 bin;
        logic [PW:0]                 gray;
        logic [PW:0]                 peer_meta;
        logic [PW:0]                 peer_sync;
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } wside_s;

    typedef struct packed {
        logic [PW:0] bin;
        logic [PW:0] gray;
        logic [PW:0] peer_meta;
        logic [PW:0] peer_sync;
    } rside_s;

    wside_s w_q, w_d;
    rside_s r_q, r_d;
    logic   full;
    logic   empty;

    ////////////////////////////////////////////////////////////////////////////
    // fill side
    assign full     = w_q.gray == {~w_q.peer_sync[PW:PW-1], w_q.peer_sync[PW-2:0]};
    assign wr_ready = ~full;

    always_comb begin
        w_d           = w_q;
        w_d.peer_meta = r_q.gray;
        w_d.peer_sync = w_q.peer_meta;
        if (wr_valid && !full) begin
            w_d.mem[w_q.bin[PW-1:0]] = wr_data;
            w_d.bin                  = w_q.bin + 1'b1;
            w_d.gray                 = w_d.bin ^ (w_d.bin >> 1);
        end
        if (wr_rst) begin
            w_d.bin  = '0;
            w_d.gray = '0;
        end
    end

    always_ff @(posedge wr_clk) begin
        w_q <= w_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // drain side
    assign empty    = r_q.gray == r_q.peer_sync;
    assign rd_valid = ~empty;
    assign rd_data  = w_q.mem[r_q.bin[PW-1:0]];

    always_comb begin
        r_d           = r_q;
        r_d.peer_meta = w_q.gray;
        r_d.peer_sync = r_q.peer_meta;
        if (rd_ready && !empty) begin
            r_d.bin  = r_q.bin + 1'b1;
            r_d.gray = r_d.bin ^ (r_d.bin >> 1);
        end
        if (rd_rst) begin
            r_d.bin  = '0;
            r_d.gray = '0;
        end
    end

    always_ff @(posedge rd_clk) begin
        r_q <= r_d;
    end
endmodule : cdc_word_fifo

//--- logic/ddr_burst_sram_port.sv
// Purpose: device side of a two-word burst DDR SRAM bus port
// Assumes: LINK_CLK is the input timing clock; its falling edge stands for
//          the inverse clock rise, and zero-skew output clocks
// Notes:   the array is flip-flops; completed write bursts are logged to
//          the core clock through a dual-clock FIFO
// Operation
// RULE1: strobe low, direction low starts write burst
// RULE2: read words driven t+1 inverse, t+2 primary
// RULE3: second word address flips address LSB
// RULE4: first address captured at start cycle
// RULE5: burst cycles counted from command cycle t
// RULE6: x18 mask bits gate two nine-bit lanes
// RULE7: x18 all mask high writes nothing
// RULE8: x36 mask bits gate four nine-bit lanes
// RULE9: x36 all mask high writes nothing
// RULE10: mask sampled separately with each data word
// RULE11: powers up deselected, outputs high-impedance
// RULE12: write data taken on both input edges
// RULE13: master parks clocks at fixed levels when stopped
// RULE14: strobe high starts nothing, direction ignored
// RULE15: stopped clocks hold outputs and state
// RULE16: deselect finishes pending read then tristates
// RULE17: output clocks high at power on: single clock
// RULE18: master leaves a gap before write after read
// RULE19: loop bypass grounded gives one-cycle read latency
`timescale 1ns/10ps
module ddr_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int DATA_W    = DATA_W_DFLT,
    parameter int ADDR_W    = ADDR_W_DFLT,
    parameter int LOG_DEPTH = LOG_DEPTH_DFLT
) (
    // core clock and reset
    input  wire logic                          CORE_CLK,
    input  wire logic                          RST,
    // link pins, all timed by LINK_CLK
    input  wire logic                          LINK_CLK,
    input  wire logic                          OPERATION_STROBE_N,
    input  wire logic                          TRANSFER_DIRECTION,
    input  wire logic [ADDR_W-1:0]             ADDR,
    input  wire logic [DATA_W-1:0]             DQ_IN,
    output logic      [DATA_W-1:0]             DQ_OUT,
    output logic                               DQ_OE,
    input  wire logic [DATA_W/LANE_W-1:0]      LANE_WRITE_MASK_N,
    // straps
    input  wire logic                          OUT_TIMING_P,
    input  wire logic                          OUT_TIMING_N,
    input  wire logic                          LOOP_BYPASS_PIN,
    // write log towards the core
    output logic                               LOG_VALID,
    input  wire logic                          LOG_READY,
    output logic      [ADDR_W-1:0]             LOG_ADDR,
    output logic      [DATA_W-1:0]             LOG_WORD1,
    output logic      [DATA_W-1:0]             LOG_WORD2,
    output logic      [DATA_W/LANE_W-1:0]      LOG_MASK1_N,
    output logic      [DATA_W/LANE_W-1:0]      LOG_MASK2_N,
    // status towards the core
    output logic                               LOG_DROPPED,
    output logic                               SINGLE_CLOCK_MODE,
    output logic                               LOOP_BYPASSED
);
    localparam int LANES = DATA_W / LANE_W;
    localparam int WORDS = 1 << ADDR_W;
    localparam int LOG_W = ADDR_W + 2 * DATA_W + 2 * LANES;

    if (!(DATA_W == 18 || DATA_W == 36) || ADDR_W < 1) begin : g_chk
        $error("ddr_burst_sram_port: DATA_W must be 18 or 36, ADDR_W at least 1");
    end

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] word_t;
    typedef logic [LANES-1:0]  mask_t;

    // state on the input timing rise
    typedef struct packed {
        logic                    rst_meta;
        logic                    rst_q;
        logic [1:0]              strap_meta;
        logic [1:0]              strap_sync;
        logic                    byp_meta;
        logic                    byp_sync;
        logic                    strap_taken;
        logic                    single_clk;
        logic                    dll_off;
        logic                    rd0;
        addr_t                   rd0_addr;
        logic                    rd1;
        addr_t                   rd1_addr;
        logic                    wr0;
        addr_t                   wr0_addr;
        logic                    wr1;
        addr_t                   wr1_addr;
        word_t                   wr1_word;
        mask_t                   wr1_mask;
        word_t                   p_data;
        logic                    p_oe;
        logic                    push_v;
        logic [LOG_W-1:0]        push_data;
        logic                    dropped;
        logic [WORDS-1:0][DATA_W-1:0] mem;
    } rise_s;

    // state on the inverse clock rise
    typedef struct packed {
        word_t n_data;
        logic  n_oe;
        word_t w2_word;
        mask_t w2_mask;
    } fall_s;

    // state on the core clock
    typedef struct packed {
        logic [2:0]       st_meta;
        logic [2:0]       st_sync;
        logic             out_valid;
        logic [LOG_W-1:0] out_data;
    } core_s;

    rise_s            rq, rd;
    fall_s            fq, fd;
    core_s            cq, cd;
    logic             fifo_ready;
    logic             fifo_valid;
    logic             fifo_take;
    logic [LOG_W-1:0] fifo_data;

    function automatic addr_t burst_partner(input addr_t a);
        return a ^ {{(ADDR_W-1){1'b0}}, BURST_LSB_FLIP}; // RULE3
    endfunction : burst_partner

    function automatic word_t lane_merge(input word_t old_w, input word_t new_w,
                                         input mask_t mask_n);
        word_t r;
        r = old_w;
        for (int l = 0; l < LANES; l++) begin
            if (mask_n[l] == LANE_WRITE) begin
                r[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W]; // RULE6 RULE8
            end
        end
        // a fully masked word leaves r equal to the old contents
        return r; // RULE7 RULE9
    endfunction : lane_merge

    ////////////////////////////////////////////////////////////////////////////
    // link side, input timing rise
    always_comb begin
        rd            = rq;
        // core reset and the straps reach the link through two flops
        rd.rst_meta   = RST;
        rd.rst_q      = rq.rst_meta;
        rd.strap_meta = {OUT_TIMING_P, OUT_TIMING_N};
        rd.strap_sync = rq.strap_meta;
        rd.byp_meta   = LOOP_BYPASS_PIN;
        rd.byp_sync   = rq.byp_meta;
        rd.dll_off    = rq.byp_sync == BYPASS_ACTIVE; // RULE19
        rd.push_v     = 1'b0;
        rd.p_oe       = 1'b0;

        // the strap is fixed once caught after reset release
        if (!rq.strap_taken) begin
            rd.single_clk  = &rq.strap_sync; // RULE17
            rd.strap_taken = 1'b1;
        end

        // older burst's second word lands first so a newer first word wins
        if (rq.wr1) begin
            rd.mem[burst_partner(rq.wr1_addr)] =
                lane_merge(rq.mem[burst_partner(rq.wr1_addr)], fq.w2_word,
                           fq.w2_mask); // RULE10 RULE12
            rd.push_v    = 1'b1;
            rd.push_data = {rq.wr1_addr, rq.wr1_word, fq.w2_word, rq.wr1_mask, fq.w2_mask};
        end
        rd.wr1 = rq.wr0;
        if (rq.wr0) begin
            rd.mem[rq.wr0_addr] = lane_merge(rd.mem[rq.wr0_addr], DQ_IN,
                                             LANE_WRITE_MASK_N); // RULE1 RULE5 RULE12
            rd.wr1_addr = rq.wr0_addr;
            rd.wr1_word = DQ_IN;
            rd.wr1_mask = LANE_WRITE_MASK_N; // RULE10
        end

        // a log record still unaccepted at this edge is lost
        if (rq.push_v && !fifo_ready) begin
            rd.dropped = 1'b1;
        end

        // read launch on the primary rise
        rd.rd1      = rq.rd0;
        rd.rd1_addr = rq.rd0_addr;
        if (rq.dll_off && rq.rd0) begin
            rd.p_oe   = 1'b1; // RULE19
            rd.p_data = rq.mem[rq.rd0_addr];
        end else if (!rq.dll_off && rq.rd1) begin
            rd.p_oe   = 1'b1; // RULE2 RULE5
            rd.p_data = rq.mem[burst_partner(rq.rd1_addr)];
        end

        // command decode
        rd.rd0 = 1'b0;
        rd.wr0 = 1'b0;
        if (OPERATION_STROBE_N == STROBE_ACTIVE) begin
            if (TRANSFER_DIRECTION == DIR_READ) begin
                rd.rd0      = 1'b1; // RULE2
                rd.rd0_addr = ADDR; // RULE4
            end else begin
                rd.wr0      = 1'b1; // RULE1
                rd.wr0_addr = ADDR; // RULE4
            end
        end // RULE14

        if (rq.rst_q) begin
            rd.strap_taken = 1'b0;
            rd.single_clk  = 1'b0;
            rd.rd0         = PEND_RST;
            rd.rd1         = PEND_RST;
            rd.wr0         = PEND_RST;
            rd.wr1         = PEND_RST;
            rd.p_oe        = OE_RST; // RULE11
            rd.p_data      = '0;
            rd.push_v      = 1'b0;
            rd.dropped     = 1'b0;
        end
    end

    // no edges, no change: a stopped link clock freezes this state
    always_ff @(posedge LINK_CLK) begin
        rq <= rd; // RULE15
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side, inverse clock rise
    always_comb begin
        fd      = fq;
        fd.n_oe = 1'b0;
        if (rq.rd1) begin
            fd.n_oe   = 1'b1; // RULE2 RULE16
            fd.n_data = rq.dll_off ? rq.mem[burst_partner(rq.rd1_addr)]
                                   : rq.mem[rq.rd1_addr];
        end
        if (rq.wr1) begin
            fd.w2_word = DQ_IN; // RULE1 RULE12
            fd.w2_mask = LANE_WRITE_MASK_N; // RULE10
        end
        if (rq.rst_q) begin
            fd.n_oe   = OE_RST; // RULE11
            fd.n_data = '0;
        end
    end

    always_ff @(negedge LINK_CLK) begin
        fq <= fd;
    end

    // each half of the link period shows the flop launched at its own edge;
    // a deselected port falls back to high impedance after its last word
    assign DQ_OUT = LINK_CLK ? rq.p_data : fq.n_data;
    assign DQ_OE  = LINK_CLK ? rq.p_oe : fq.n_oe; // RULE16

    ////////////////////////////////////////////////////////////////////////////
    // write log crossing into the core clock
    cdc_word_fifo #(
        .WIDTH (LOG_W),
        .DEPTH (LOG_DEPTH)
    ) u_log_fifo (
        .wr_clk   (LINK_CLK),
        .wr_rst   (rq.rst_q),
        .wr_valid (rq.push_v),
        .wr_ready (fifo_ready),
        .wr_data  (rq.push_data),
        .rd_clk   (CORE_CLK),
        .rd_rst   (RST),
        .rd_valid (fifo_valid),
        .rd_ready (fifo_take),
        .rd_data  (fifo_data)
    );

    // the output stage drains the FIFO only when it can hold the word
    assign fifo_take = !cq.out_valid || LOG_READY;

    always_comb begin
        cd         = cq;
        cd.st_meta = {rq.dropped, rq.single_clk, rq.dll_off};
        cd.st_sync = cq.st_meta;
        if (fifo_take) begin
            cd.out_valid = fifo_valid;
            if (fifo_valid) begin
                cd.out_data = fifo_data;
            end
        end
        if (RST) begin
            cd.out_valid = 1'b0;
            cd.out_data  = '0;
            cd.st_sync   = '0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        cq <= cd;
    end

    assign LOG_VALID         = cq.out_valid;
    assign {LOG_ADDR, LOG_WORD1, LOG_WORD2, LOG_MASK1_N, LOG_MASK2_N} = cq.out_data;
    assign LOG_DROPPED       = cq.st_sync[2];
    assign SINGLE_CLOCK_MODE = cq.st_sync[1];
    assign LOOP_BYPASSED     = cq.st_sync[0];
endmodule : ddr_burst_sram_port

//--- tb/sram_port_monitor.sv
// Purpose: port checks for the burst SRAM port
// Assumes: delay loop on, zero-skew output timing
// Notes:   a read at t owns DQ_OE from the t+1 low phase to the t+2 high phase
`timescale 1ns/10ps
module sram_port_monitor #(
    parameter int ADDR_W = 6
) (
    // clocks and reset
    input wire logic              CORE_CLK,
    input wire logic              RST,
    input wire logic              LINK_CLK,
    // link side
    input wire logic              OPERATION_STROBE_N,
    input wire logic              TRANSFER_DIRECTION,
    input wire logic              DQ_OE,
    input wire logic              LOOP_BYPASS_PIN,
    // core side
    input wire logic              LOG_VALID,
    input wire logic              LOG_READY,
    input wire logic [ADDR_W-1:0] LOG_ADDR,
    input wire logic              LOG_DROPPED,
    input wire logic              LOOP_BYPASSED
);
    ////////////////////////////////////////////////
    // read commands seen one, two and three link cycles ago
    logic rd1_q, rd2_q, rd3_q;
    always_ff @(posedge LINK_CLK) begin
        rd1_q <= !RST && !OPERATION_STROBE_N && TRANSFER_DIRECTION;
        rd2_q <= !RST && rd1_q;
        rd3_q <= !RST && rd2_q;
    end
    property p_rd_lat;
        @(posedge LINK_CLK) disable iff (RST)
        !OPERATION_STROBE_N && TRANSFER_DIRECTION |-> ##2 DQ_OE;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read drive late");
    property p_wr_quiet;
        @(posedge LINK_CLK) disable iff (RST)
        !OPERATION_STROBE_N && !TRANSFER_DIRECTION |-> ##2 !DQ_OE;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("drive on write");
    property p_oe_cause;
        @(posedge LINK_CLK) disable iff (RST) DQ_OE |-> rd2_q;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("drive without read");
    property p_oe_second;
        @(negedge LINK_CLK) disable iff (RST) DQ_OE == rd3_q;
    endproperty
    a_oe_second: assert property (p_oe_second) else $error("second word phase");
    property p_nop_quiet;
        @(posedge LINK_CLK) disable iff (RST) OPERATION_STROBE_N [*3] |-> !DQ_OE;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("drive when idle");
    // a record not taken must not change under the core
    property p_log_hold;
        @(posedge CORE_CLK) disable iff (RST)
        LOG_VALID && !LOG_READY |=> LOG_VALID && $stable(LOG_ADDR);
    endproperty
    a_log_hold: assert property (p_log_hold) else $error("log record changed");
    property p_drop_sticky;
        @(posedge CORE_CLK) disable iff (RST) LOG_DROPPED |=> LOG_DROPPED;
    endproperty
    a_drop_sticky: assert property (p_drop_sticky) else $error("drop flag cleared");
    property p_bypass_off;
        @(posedge CORE_CLK) disable iff (RST) LOOP_BYPASS_PIN [*8] |-> !LOOP_BYPASSED;
    endproperty
    a_bypass_off: assert property (p_bypass_off) else $error("bypass flag");
endmodule : sram_port_monitor
bind ddr_burst_sram_port sram_port_monitor #(.ADDR_W(ADDR_W))
    sram_port_monitor_i (.*);

//--- tb/sram_bus_master.sv
// Purpose: bus master model on the link pins
// Assumes: link clock runs free, the delay loop needs it stable
// Notes:   released data lines show the inverse of the last word
`timescale 1ns/10ps
module sram_bus_master (
    // link clock
    input  wire logic        link_clk,
    // command and mask pins
    output logic             strobe_n,
    output logic             dir,
    output logic [5:0]       addr,
    output logic [1:0]       mask_n,
    // shared data wire, resolved here
    output logic [17:0]      dq_in,
    input  wire logic [17:0] dq_out,
    input  wire logic        dq_oe
);
    logic [17:0] drv;
    assign dq_in = dq_oe ? dq_out : drv;
    initial begin
        strobe_n = 1'h1;
        dir      = 1'h0;
        addr     = 6'h00;
        mask_n   = 2'h3;
        drv      = 18'h00000;
    end
    ////////////////////////////////////////////////
    // a spare edge first, so a write never follows a read back to back
    task automatic start(input logic rd, input logic [5:0] a);
        @(posedge link_clk) #1;
        strobe_n = 1'h0;
        dir      = rd;
        addr     = a;
        @(posedge link_clk) #1;
        strobe_n = 1'h1;
        addr     = ~a;
    endtask : start
    task automatic write(input logic [5:0] a, input logic [17:0] w1, w2,
                         input logic [1:0] m1, m2);
        start(1'h0, a);
        drv    = w1;
        mask_n = m1;
        @(posedge link_clk) #1;
        drv    = w2;
        mask_n = m2;
        @(negedge link_clk) #1;
        drv    = ~w2;
        mask_n = ~m2;
    endtask : write
    task automatic read(input logic [5:0] a, output logic [17:0] w1, w2,
                        output logic [2:0] oe);
        start(1'h1, a);
        @(posedge link_clk);
        @(negedge link_clk) #20;
        w1    = dq_out;
        oe[2] = dq_oe;
        @(posedge link_clk) #20;
        w2    = dq_out;
        oe[1] = dq_oe;
        @(negedge link_clk) #20;
        oe[0] = dq_oe;
    endtask : read
    task automatic idle(input int n, output logic seen);
        seen = 1'h0;
        repeat (n) begin
            @(posedge link_clk) #1;
            dir = ~dir;
            @(negedge link_clk) #20;
            seen = seen | dq_oe;
        end
    endtask : idle
endmodule : sram_bus_master

//--- tb/testbench.sv
// Purpose: self-checking bench for the burst SRAM port
// Assumes: output timing straps low, loop bypass strap high, delay loop on
// Notes:   a shadow array gives every expected read word
`timescale 1ns/10ps
module testbench;
    import sram_port_pkg::*;
    logic        core_clk, link_clk, rst, log_ready, log_valid, dq_oe;
    logic        strobe_n, dir, dropped, single, bypassed;
    logic [5:0]  addr, log_addr;
    logic [1:0]  mask_n, log_m1, log_m2;
    logic [17:0] dq_in, dq_out, log_w1, log_w2;
    logic [17:0] shadow [64];
    int          n_mismatch, checked;
    ddr_burst_sram_port ddr_burst_sram_port_i (
        .CORE_CLK(core_clk), .RST(rst), .LINK_CLK(link_clk), .ADDR(addr),
        .OPERATION_STROBE_N(strobe_n), .TRANSFER_DIRECTION(dir), .DQ_IN(dq_in),
        .DQ_OUT(dq_out), .DQ_OE(dq_oe), .LANE_WRITE_MASK_N(mask_n),
        .OUT_TIMING_P(1'h0), .OUT_TIMING_N(1'h0), .LOOP_BYPASS_PIN(1'h1),
        .LOG_VALID(log_valid), .LOG_READY(log_ready), .LOG_ADDR(log_addr),
        .LOG_WORD1(log_w1), .LOG_WORD2(log_w2), .LOG_MASK1_N(log_m1),
        .LOG_MASK2_N(log_m2), .LOG_DROPPED(dropped), .SINGLE_CLOCK_MODE(single),
        .LOOP_BYPASSED(bypassed));
    sram_bus_master sram_bus_master_i (
        .link_clk(link_clk), .strobe_n(strobe_n), .dir(dir), .addr(addr),
        .mask_n(mask_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'h0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    ////////////////////////////////////////////////
    task automatic chk(input string what, input logic [17:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    function automatic logic [17:0] merge(logic [17:0] old, nw, logic [1:0] m);
        merge = old;
        for (int l = 0; l < 2; l++)
            if (m[l] == LANE_WRITE)
                merge[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
    endfunction : merge
    task automatic get_log(input logic [5:0] a, input logic [17:0] w1, w2,
                           input logic [1:0] m1, m2);
        int i;
        for (i = 0; i < 40 && log_valid !== 1'h1; i++)
            @(posedge core_clk) #1;
        if (i == 40) begin
            n_mismatch++;
            end_sim();
        end
        chk("log addr", 18'(log_addr), 18'(a));
        chk("log word1", log_w1, w1);
        chk("log word2", log_w2, w2);
        chk("log masks", 18'({log_m1, log_m2}), 18'({m1, m2}));
        log_ready = 1'h1;
        @(posedge core_clk) #1;
        log_ready = 1'h0;
        @(posedge core_clk) #1;
    endtask : get_log
    task automatic do_wr(input logic [5:0] a, input logic [17:0] w1, w2,
                         input logic [1:0] m1, m2, input logic pop);
        sram_bus_master_i.write(a, w1, w2, m1, m2);
        shadow[a] = merge(shadow[a], w1, m1);
        shadow[a ^ 6'h01] = merge(shadow[a ^ 6'h01], w2, m2);
        if (pop)
            get_log(a, w1, w2, m1, m2);
    endtask : do_wr
    task automatic do_rd(input logic [5:0] a);
        logic [17:0] w1, w2;
        logic [2:0]  oe;
        sram_bus_master_i.read(a, w1, w2, oe);
        chk("read word1", w1, shadow[a]);
        chk("read word2", w2, shadow[a ^ 6'h01]);
        chk("read phases", 18'(oe), 18'h00006);
    endtask : do_rd
    ////////////////////////////////////////////////
    task automatic t_reset;
        chk("drive enable", 18'(dq_oe), 18'h0);
        chk("log valid", 18'(log_valid), 18'h0);
        chk("dropped", 18'(dropped), 18'h0);
        chk("single clock", 18'(single), 18'h0);
        chk("bypassed", 18'(bypassed), 18'h0);
    endtask : t_reset
    task automatic t_burst;
        do_wr(6'h05, 18'h1a5a5, 18'h25a5a, 2'h0, 2'h0, 1'h1);
        do_rd(6'h05);
        do_rd(6'h04);
    endtask : t_burst
    task automatic t_mask;
        do_wr(6'h08, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0, 1'h1);
        do_wr(6'h08, 18'h00000, 18'h00000, 2'h2, 2'h1, 1'h1);
        do_wr(6'h09, 18'h00000, 18'h00000, 2'h3, 2'h3, 1'h1);
        do_rd(6'h08);
    endtask : t_mask
    task automatic t_idle;
        logic seen;
        sram_bus_master_i.idle(6, seen);
        chk("idle drive", 18'(seen), 18'h0);
        chk("idle log", 18'(log_valid), 18'h0);
    endtask : t_idle
    // core stalls while ten bursts arrive; eight wait in the FIFO and one
    // in the output stage, so only the tenth record is lost
    task automatic t_fill;
        int i;
        for (i = 0; i < 10; i++)
            do_wr(6'h10 + 6'(2 * i), 18'(i), 18'(~i), 2'h0, 2'h0, 1'h0);
        for (i = 0; i < 40 && dropped !== 1'h1; i++)
            @(posedge core_clk) #1;
        chk("dropped", 18'(dropped), 18'h1);
        for (i = 0; i < 9; i++)
            get_log(6'h10 + 6'(2 * i), 18'(i), 18'(~i), 2'h0, 2'h0);
        chk("log empty", 18'(log_valid), 18'h0);
        do_rd(6'h12);
    endtask : t_fill
    initial begin
        rst        = 1'h1;
        log_ready  = 1'h0;
        n_mismatch = 0;
        checked    = 0;
        repeat (20) @(posedge core_clk);
        #1 rst = 1'h0;
        repeat (5) @(posedge link_clk);
        #1;
        t_reset();
        t_burst();
        t_mask();
        t_idle();
        t_fill();
        end_sim();
    end
endmodule : testbench
